// file: crd_cascade_role_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "crd_regs.vh"

module crd_cascade_role_decoder #(
  parameter LINE_TICKS = `CRD_CHIP_COLS,
  parameter ROW_COUNT  = `CRD_CHIP_ROWS
) (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       role_select_low_pad,
  input  wire       role_select_high_pad,
  input  wire       clock_source_pad,
  input  wire       leader_chip_select_n,
  input  wire       follower_chip_select_n,
  input  wire       link_clock_in,
  input  wire       frame_sync_in,
  input  wire       line_sync_in,
  input  wire       cascade_data_in,
  input  wire       cascade_data_src,
  output wire [1:0] role_code,
  output wire       role_valid,
  output wire       top_leader_role,
  output wire       top_follower_role,
  output wire       bottom_leader_role,
  output wire       bottom_follower_role,
  output wire [1:0] clock_source_sel,
  output wire       host_selected,
  output wire       system_clock_out,
  output wire       system_clock_out_oe,
  output wire       frame_sync_out,
  output wire       frame_sync_out_oe,
  output wire       line_sync_out,
  output wire       line_sync_out_oe,
  output wire       cascade_data_out,
  output wire       cascade_data_out_oe,
  output wire       cascade_data_rx,
  output wire       row_driver_ctrl_a,
  output wire       row_driver_ctrl_b,
  output wire       row_drivers_oe,
  output wire       line_start,
  output wire       frame_start,
  output wire [8:0] col_index,
  output wire [7:0] row_index,
  output wire [8:0] col_base,
  output wire [7:0] row_base
);

  // last indices, cut to the width of the counters they are compared with
  localparam integer COL_LAST_INT = LINE_TICKS - 1;
  localparam integer ROW_LAST_INT = ROW_COUNT - 1;
  localparam [8:0]   COL_LAST     = COL_LAST_INT[8:0];
  localparam [7:0]   ROW_LAST     = ROW_LAST_INT[7:0];

  // rising edge of a synchronised level against its previous sample
  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  // one role decode, held off until the straps are latched
  function role_match;
    input       done;
    input [1:0] code;
    input [1:0] want;
    begin
      role_match = done & (code == want);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  reg  [`CRD_IN_WIDTH-1:0] sync1_reg;
  reg  [`CRD_IN_WIDTH-1:0] sync2_reg;
  reg  [`CRD_IN_WIDTH-1:0] prev_reg;
  wire [`CRD_IN_WIDTH-1:0] pins;

  assign pins = {cascade_data_in, line_sync_in, frame_sync_in, link_clock_in, follower_chip_select_n,
                 leader_chip_select_n, clock_source_pad, role_select_high_pad, role_select_low_pad};

  // two flops per pin, then one more sample for edge finding
  // zero is the idle level of the sync and clock pins, so reset makes no false edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= {`CRD_IN_WIDTH{1'b0}};
      sync2_reg <= {`CRD_IN_WIDTH{1'b0}};
      prev_reg  <= {`CRD_IN_WIDTH{1'b0}};
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire link_rise  = rise(sync2_reg[`CRD_IN_LINK_CLK], prev_reg[`CRD_IN_LINK_CLK]);
  wire frame_rise = rise(sync2_reg[`CRD_IN_FRAME], prev_reg[`CRD_IN_FRAME]);
  wire line_rise  = rise(sync2_reg[`CRD_IN_LINE], prev_reg[`CRD_IN_LINE]);

  // ----------------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------------
  reg [1:0] settle_reg;
  reg       strap_done_reg;
  reg [1:0] role_reg;
  reg [1:0] clk_sel_reg;

  // wait for the synchronisers to fill, then latch the straps once
  // pad changes after the capture are ignored until the next reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
      role_reg       <= `CRD_ROLE_RESET;
      clk_sel_reg    <= `CRD_CLKSEL_RESET;
    end else if (!strap_done_reg) begin
      if (settle_reg == `CRD_STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        role_reg       <= {sync2_reg[`CRD_IN_HIGH_PAD], sync2_reg[`CRD_IN_LOW_PAD]};
        clk_sel_reg    <= {sync2_reg[`CRD_IN_CLK_PAD], sync2_reg[`CRD_IN_LOW_PAD]};
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // role decode, nothing is active until the straps are latched
  // exactly one role flag is high once role_valid is set
  wire is_tl = role_match(strap_done_reg, role_reg, `CRD_ROLE_TOP_LEADER);
  wire is_tf = role_match(strap_done_reg, role_reg, `CRD_ROLE_TOP_FOLLOWER);
  wire is_bl = role_match(strap_done_reg, role_reg, `CRD_ROLE_BOTTOM_LEADER);
  wire is_bf = role_match(strap_done_reg, role_reg, `CRD_ROLE_BOTTOM_FOLLOWER);
  wire leader = is_tl | is_bl;

  assign role_code            = role_reg;
  assign role_valid           = strap_done_reg;
  assign top_leader_role      = is_tl;
  assign top_follower_role    = is_tf;
  assign bottom_leader_role   = is_bl;
  assign bottom_follower_role = is_bf;
  assign clock_source_sel     = clk_sel_reg;

  // ----------------------------------------------------------------------------
  // forwarded system clock
  // ----------------------------------------------------------------------------
  reg clk_div_reg;

  // half-rate copy of the internal clock for the followers
  // its phase is fixed by reset, so the leader's column ticks line up with it
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clk_div_reg <= 1'b0;
    end else begin
      clk_div_reg <= ~clk_div_reg;
    end
  end

  wire own_tick = ~clk_div_reg; // forwarded clock rises on the next edge

  // ----------------------------------------------------------------------------
  // scan timing: top leader generates, everyone else tracks
  // ----------------------------------------------------------------------------
  reg  [8:0] col_reg;
  reg  [7:0] row_reg;
  reg  [8:0] col_next;
  reg  [7:0] row_next;
  reg        line_start_next;
  reg        frame_start_next;
  wire [7:0] row_inc = (row_reg == ROW_LAST) ? 8'h00 : row_reg + 8'h01;

  // next scan position
  // followers stop at the last column instead of wrapping, a lost line pulse never aliases
  always @* begin
    col_next         = col_reg;
    row_next         = row_reg;
    line_start_next  = 1'b0;
    frame_start_next = 1'b0;
    if (!strap_done_reg) begin
      col_next = 9'h000;
      row_next = 8'h00;
    end else if (is_tl) begin
      if (own_tick) begin
        if (col_reg == COL_LAST) begin
          col_next         = 9'h000;
          row_next         = row_inc;
          line_start_next  = 1'b1;
          frame_start_next = (row_inc == 8'h00);
        end else begin
          col_next = col_reg + 9'h001;
        end
      end
    end else if (frame_rise) begin
      col_next         = 9'h000;
      row_next         = 8'h00;
      line_start_next  = 1'b1;
      frame_start_next = 1'b1;
    end else if (line_rise) begin
      col_next        = 9'h000;
      row_next        = row_inc;
      line_start_next = 1'b1;
    end else if (link_rise && col_reg != COL_LAST) begin
      col_next = col_reg + 9'h001;
    end
  end

  reg line_start_reg;
  reg frame_start_reg;

  // scan position and start pulses
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      col_reg         <= 9'h000;
      row_reg         <= 8'h00;
      line_start_reg  <= 1'b0;
      frame_start_reg <= 1'b0;
    end else begin
      col_reg         <= col_next;
      row_reg         <= row_next;
      line_start_reg  <= line_start_next;
      frame_start_reg <= frame_start_next;
    end
  end

  assign line_start  = line_start_reg;
  assign frame_start = frame_start_reg;
  assign col_index   = col_reg;
  assign row_index   = row_reg;

  // followers take the right half, bottom chips the lower rows
  assign col_base = leader ? 9'h000 : `CRD_COL_HALF_BASE;
  assign row_base = role_reg[1] ? 8'h00 : `CRD_ROW_HALF_BASE;

  // ----------------------------------------------------------------------------
  // cascade outputs and row driver controls
  // ----------------------------------------------------------------------------
  reg frame_sync_reg;
  reg line_sync_reg;
  reg data_out_reg;
  reg data_rx_reg;
  reg ctrl_a_reg;
  reg ctrl_b_reg;
  reg host_sel_reg;

  // each role listens to its own select only
  wire leader_cs_hit   = ~sync2_reg[`CRD_IN_CS1_N];
  wire follower_cs_hit = strap_done_reg & ~sync2_reg[`CRD_IN_CS2_N];

  // top leader sources sync, bottom leader repeats what it receives
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_sync_reg <= 1'b0;
      line_sync_reg  <= 1'b0;
      data_out_reg   <= 1'b0;
      data_rx_reg    <= 1'b0;
      ctrl_a_reg     <= 1'b0;
      ctrl_b_reg     <= 1'b0;
      host_sel_reg   <= 1'b0;
    end else begin
      frame_sync_reg <= is_tl ? (row_next == 8'h00) : (is_bl & sync2_reg[`CRD_IN_FRAME]);
      line_sync_reg  <= is_tl ? (col_next == 9'h000) : (is_bl & sync2_reg[`CRD_IN_LINE]);
      data_out_reg   <= is_tl & cascade_data_src;
      data_rx_reg    <= ~is_tl & sync2_reg[`CRD_IN_DATA];
      ctrl_a_reg     <= is_tl & (col_next == 9'h000);
      ctrl_b_reg     <= is_tl & row_next[0];
      host_sel_reg   <= leader ? leader_cs_hit : follower_cs_hit;
    end
  end

  // pad enables follow the role, nothing drives a pad before the straps are latched
  assign system_clock_out    = clk_div_reg;
  assign system_clock_out_oe = leader;
  assign frame_sync_out      = frame_sync_reg;
  assign frame_sync_out_oe   = is_tl | is_bl;
  assign line_sync_out       = line_sync_reg;
  assign line_sync_out_oe    = is_tl | is_bl;
  assign cascade_data_out    = data_out_reg;
  assign cascade_data_out_oe = is_tl;
  assign cascade_data_rx     = data_rx_reg;
  assign row_driver_ctrl_a   = ctrl_a_reg;
  assign row_driver_ctrl_b   = ctrl_b_reg;
  assign row_drivers_oe      = is_tl;
  assign host_selected       = host_sel_reg;

endmodule // crd_cascade_role_decoder

`default_nettype wire

// file: crd_cascade_role_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// port checker
// ------
module crd_cascade_role_decoder_asserts (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [1:0] role_code,
  input wire logic       role_valid,
  input wire logic       top_leader_role,
  input wire logic       top_follower_role,
  input wire logic       bottom_leader_role,
  input wire logic       bottom_follower_role,
  input wire logic [1:0] clock_source_sel,
  input wire logic       host_selected,
  input wire logic       leader_chip_select_n,
  input wire logic       follower_chip_select_n,
  input wire logic       system_clock_out,
  input wire logic       frame_sync_out_oe,
  input wire logic       line_sync_out_oe,
  input wire logic       cascade_data_out_oe,
  input wire logic       line_sync_out,
  input wire logic       row_driver_ctrl_a,
  input wire logic       row_driver_ctrl_b,
  input wire logic       row_drivers_oe,
  input wire logic [8:0] col_base,
  input wire logic [7:0] row_base
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // either leader role
  wire ldr = top_leader_role | bottom_leader_role;
  a_role_decode: assert property (role_valid |-> {top_leader_role, top_follower_role,
    bottom_leader_role, bottom_follower_role} == 4'h1 << role_code) else $error("role decode wrong");
  a_role_frozen: assert property ($past(role_valid) && role_valid |-> role_code == $past(role_code))
    else $error("role changed");
  a_row_gating: assert property (row_drivers_oe == top_leader_role
    && (top_leader_role || !(row_driver_ctrl_a || row_driver_ctrl_b))) else $error("row control gating");
  a_sync_enable: assert property (frame_sync_out_oe == ldr && line_sync_out_oe == ldr
    && cascade_data_out_oe == top_leader_role) else $error("sync enables wrong");
  a_leader_select: assert property ((role_valid && ldr && $stable(leader_chip_select_n))[*5]
    |-> host_selected == !leader_chip_select_n) else $error("leader select wrong");
  a_follower_select: assert property ((role_valid && !ldr && $stable(follower_chip_select_n))[*5]
    |-> host_selected == !follower_chip_select_n) else $error("follower select wrong");
  a_clock_forward: assert property (role_valid && $past(role_valid)
    |-> system_clock_out != $past(system_clock_out)) else $error("clock not forwarded");
  a_clock_select: assert property (role_valid |-> clock_source_sel[0] == role_code[0])
    else $error("clock source wrong");
  a_panel_base: assert property (role_valid |-> col_base == (role_code[0] ? 9'h0 : 9'h100)
    && row_base == (role_code[1] ? 8'h0 : 8'h48)) else $error("panel base wrong");
  a_line_pulse: assert property (top_leader_role && $rose(line_sync_out)
    |=> line_sync_out ##1 !line_sync_out) else $error("line sync width");
endmodule // crd_cascade_role_decoder_asserts
bind crd_cascade_role_decoder crd_cascade_role_decoder_asserts u_chk (.clk_sys, .resetn, .role_code,
  .role_valid, .top_leader_role, .top_follower_role, .bottom_leader_role, .bottom_follower_role,
  .clock_source_sel, .host_selected, .leader_chip_select_n, .follower_chip_select_n, .system_clock_out,
  .frame_sync_out_oe, .line_sync_out_oe, .cascade_data_out_oe, .line_sync_out, .row_driver_ctrl_a,
  .row_driver_ctrl_b, .row_drivers_oe, .col_base, .row_base);
`default_nettype wire

// file: crd_cascade_role_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crd_cascade_role_decoder_tb;
  logic       clk_sys = 1'h0;
  logic       resetn = 1'h0;
  logic       pad_lo = 1'h0;
  logic       pad_hi = 1'h0;
  logic       pad_ck = 1'h0;
  logic       lcs_n = 1'h1;
  logic       fcs_n = 1'h1;
  logic       src = 1'h0;
  wire        lk, fs, ls, sd, valid, hsel, rd_oe, fs_oe;
  wire        ck_oe, fso, lso, dout, rx, lstart, fstart, ctl_a, ctl_b;
  localparam int TB_COLS = 8;
  localparam int TB_ROWS = 4;
  wire  [1:0] code, csel;
  wire  [8:0] col, cbase;
  wire  [7:0] row, rbase;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  crd_cascade_role_decoder #(.LINE_TICKS(TB_COLS), .ROW_COUNT(TB_ROWS)) dut (.clk_sys(clk_sys), .resetn(resetn),
    .role_select_low_pad(pad_lo), .role_select_high_pad(pad_hi), .clock_source_pad(pad_ck),
    .leader_chip_select_n(lcs_n), .follower_chip_select_n(fcs_n), .link_clock_in(lk), .frame_sync_in(fs),
    .line_sync_in(ls), .cascade_data_in(sd), .cascade_data_src(src), .role_code(code), .role_valid(valid),
    .top_leader_role(), .top_follower_role(), .bottom_leader_role(), .bottom_follower_role(),
    .clock_source_sel(csel), .host_selected(hsel), .system_clock_out(), .system_clock_out_oe(ck_oe),
    .frame_sync_out(fso), .frame_sync_out_oe(fs_oe), .line_sync_out(lso), .line_sync_out_oe(),
    .cascade_data_out(dout), .cascade_data_out_oe(), .cascade_data_rx(rx), .row_driver_ctrl_a(ctl_a),
    .row_driver_ctrl_b(ctl_b), .row_drivers_oe(rd_oe), .line_start(lstart), .frame_start(fstart),
    .col_index(col), .row_index(row), .col_base(cbase), .row_base(rbase));
  crd_leader_model u_lead (.link_clk(lk), .frame_sync(fs), .line_sync(ls), .data_out(sd));
  // clock, core data and hang guard
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    src <= ~src;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // reset with given straps, check the latched role, then move the pads
  task automatic t_role(input logic [1:0] r);
    @(posedge clk_sys);
    resetn <= 1'h0;
    pad_hi <= r[1];
    pad_lo <= r[0];
    pad_ck <= r[1] ^ r[0];
    tick(20);
    @(posedge clk_sys) resetn <= 1'h1;
    for (int i = 0; i < 20 && valid !== 1'h1; i++) tick(1);
    check("role", code, r);
    check("clksel", csel, {r[1] ^ r[0], r[0]});
    check("row oe", rd_oe, r == 2'h3);
    check("sync oe", fs_oe, r[0]);
    check("col base", cbase, r[0] ? 9'h0 : 9'h100);
    check("row base", rbase, r[1] ? 8'h0 : 8'h48);
    @(posedge clk_sys);
    pad_hi <= ~r[1];
    pad_lo <= ~r[0];
    pad_ck <= ~pad_ck;
    tick(10);
    check("held role", code, r);
    check("held clksel", csel, {r[1] ^ r[0], r[0]});
    check("clk oe", ck_oe, r[0]);
    check("data out", dout, (r == 2'h3) ? !src : 1'h0);
  endtask
  // a bottom leader repeats the top leader's syncs, nobody else drives them
  task automatic t_relay(input logic [1:0] r);
    fork
      u_lead.pulse_sync(1'h1);
      begin
        tick(8);
        check("frame relay", fso, r == 2'h1);
      end
    join
    check("frame relay end", fso, 1'h0);
    fork
      u_lead.pulse_sync(1'h0);
      begin
        tick(8);
        check("line relay", lso, r == 2'h1);
      end
    join
    check("line relay end", lso, 1'h0);
    check("data rx", rx, sd);
  endtask
  // top leader paces lines and frames from its own clock
  task automatic t_lead();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (fstart !== 1'h1 && n < 2 * TB_COLS * TB_ROWS + 8);
    check("frame start", fstart, 1'h1);
    check("frame row", row, 8'h0);
    check("frame col", col, 9'h0);
    check("frame sync", fso, 1'h1);
    check("line sync", lso, 1'h1);
    check("row ctrl a", ctl_a, 1'h1);
    check("row ctrl b low", ctl_b, 1'h0);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (lstart !== 1'h1 && n < 40);
    check("line period", n[8:0], 9'(2 * TB_COLS));
    check("next row", row, 8'h1);
    check("row ctrl b high", ctl_b, 1'h1);
    check("frame sync off", fso, 1'h0);
    check("leader data out", dout, !src);
  endtask
  // each role answers only its own select
  task automatic t_select(input logic [1:0] r);
    @(posedge clk_sys) lcs_n <= 1'h0;
    tick(6);
    check("leader sel", hsel, r[0]);
    @(posedge clk_sys);
    lcs_n <= 1'h1;
    fcs_n <= 1'h0;
    tick(6);
    check("follower sel", hsel, !r[0]);
    @(posedge clk_sys) fcs_n <= 1'h1;
  endtask
  // follower tracks the leader's syncs and forwarded clock
  task automatic t_follow();
    u_lead.pulse_sync(1'h1);
    u_lead.clocks(3);
    tick(6);
    check("col after frame", col, 9'h3);
    check("row after frame", row, 8'h0);
    u_lead.pulse_sync(1'h0);
    tick(6);
    check("row after line", row, 8'h1);
    check("col after line", col, 9'h0);
    u_lead.clocks(10);
    tick(6);
    check("col at end", col, 9'h7);
  endtask
  // every strap code in turn
  initial begin
    for (int r = 0; r < 4; r++) begin
      t_role(r[1:0]);
      t_select(r[1:0]);
      if (r == 3) t_lead();
      else t_relay(r[1:0]);
      if (!r[0]) t_follow();
    end
    report_and_stop();
  end
endmodule // crd_cascade_role_decoder_tb
`default_nettype wire

// file: crd_leader_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// leader chip as seen by a follower
// ------
module crd_leader_model (
  output var logic link_clk,
  output var logic frame_sync,
  output var logic line_sync,
  output var logic data_out
);
  // forwarded clock idles low between bursts
  initial begin
    link_clk = 1'h0;
    frame_sync = 1'h0;
    line_sync = 1'h0;
    data_out = 1'h0;
  end
  // sync pulse, wide enough for a sampled input
  task automatic pulse_sync(input logic frame);
    #7;
    if (frame) frame_sync = 1'h1;
    else line_sync = 1'h1;
    #600;
    frame_sync = 1'h0;
    line_sync = 1'h0;
    #600;
  endtask
  // n periods of the 400 ns forwarded clock
  task automatic clocks(input int n);
    #13;
    repeat (n) begin
      link_clk = 1'h1;
      data_out = ~data_out; // data keeps moving
      #200;
      link_clk = 1'h0;
      #200;
    end
  endtask
endmodule // crd_leader_model
`default_nettype wire

// file: crd_regs.vh
`ifndef CRD_REGS_VH
`define CRD_REGS_VH

// ----------------------------------------------------------------------------
// role codes, written as {role_select_high_pad, role_select_low_pad}
// ----------------------------------------------------------------------------
`define CRD_ROLE_BOTTOM_FOLLOWER 2'h0
`define CRD_ROLE_BOTTOM_LEADER   2'h1
`define CRD_ROLE_TOP_FOLLOWER    2'h2
`define CRD_ROLE_TOP_LEADER      2'h3

// ----------------------------------------------------------------------------
// strap capture and reset values
// ----------------------------------------------------------------------------
`define CRD_STRAP_SETTLE         2'h3
`define CRD_ROLE_RESET           2'h0
`define CRD_CLKSEL_RESET         2'h0

// ----------------------------------------------------------------------------
// panel geometry
// ----------------------------------------------------------------------------
`define CRD_PANEL_COLS           512
`define CRD_CHIP_COLS            256
`define CRD_CHIP_ROWS            72
`define CRD_QUAD_ROWS            144
`define CRD_GRAY_LEVELS          16
`define CRD_COL_HALF_BASE        9'h100
`define CRD_ROW_HALF_BASE        8'h48

// ----------------------------------------------------------------------------
// bit positions inside the input synchroniser vector
// ----------------------------------------------------------------------------
`define CRD_IN_LOW_PAD           0
`define CRD_IN_HIGH_PAD          1
`define CRD_IN_CLK_PAD           2
`define CRD_IN_CS1_N             3
`define CRD_IN_CS2_N             4
`define CRD_IN_LINK_CLK          5
`define CRD_IN_FRAME             6
`define CRD_IN_LINE              7
`define CRD_IN_DATA              8
`define CRD_IN_WIDTH             9

`endif
